// File: design/adcsrp_consts.vh
// constants of the serial register port: register codes, field positions, reset values, counts
// assumes inclusion by the port design file and the bench (the fifo file does not include it); definitions only
`ifndef ADCSRP_CONSTS_VH
`define ADCSRP_CONSTS_VH

// register select codes carried in the communications byte
`define ADCSRP_REG_COMM      3'h0
`define ADCSRP_REG_SETUP     3'h1
`define ADCSRP_REG_CLOCK     3'h2
`define ADCSRP_REG_DATA      3'h3
`define ADCSRP_REG_TEST      3'h4
`define ADCSRP_REG_ZERO      3'h6
`define ADCSRP_REG_FULL      3'h7

// communications byte layout
`define ADCSRP_COMM_READY    7
`define ADCSRP_COMM_SEL_HI   6
`define ADCSRP_COMM_SEL_LO   4
`define ADCSRP_COMM_RW       3
`define ADCSRP_COMM_CTRL_HI  2

// transfer lengths in serial clocks
`define ADCSRP_LEN_BYTE      5'h08
`define ADCSRP_LEN_DATA      5'h10
`define ADCSRP_LEN_CAL       5'h18

// widths
`define ADCSRP_DATA_W        16
`define ADCSRP_CAL_W         24

// reset values
`define ADCSRP_RST_SETUP     8'h01
`define ADCSRP_RST_CLOCK     8'h05
`define ADCSRP_RST_TEST      8'h00
`define ADCSRP_RST_ZERO      24'h1F4000
`define ADCSRP_RST_FULL      24'h5761AB
`define ADCSRP_RST_CTRL      3'h0

// ones on the serial input that reset the interface
`define ADCSRP_ONES_RESET    6'h20

// result buffer
`define ADCSRP_FIFO_DEPTH    8
`define ADCSRP_FIFO_AW       3

`endif

// File: design/adcsrp_fifo.v
// synchronous fifo of flip-flops with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module adcsrp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_core_clk,
    input  wire             i_rst_n,
    input  wire             i_in_valid,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_in_ready,
    output wire             o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input  wire             i_out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire push = i_in_valid & o_in_ready;
    wire pop  = o_out_valid & i_out_ready;

    // honest flags straight from the occupancy count
    assign o_in_ready  = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr];

    ////////////////////////////////////////////////////////////////////////////////
    // storage, one write port per entry
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
            always @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    mem[g] <= {WIDTH{1'b0}};
                end else if (push && (wr_ptr == g[AW-1:0])) begin
                    mem[g] <= i_in_data;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // pointers and count; depth is a power of two so pointers wrap freely
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: design/adcsrp_port.v
// serial register port of a three-channel converter: comms byte, six registers, result flag
// assumes serial clock, select and data in arrive from outside and are synchronised here;
// the serial clock must stay well below a quarter of the core clock rate
`timescale 1ns/10ps
`default_nettype none
`include "adcsrp_consts.vh"

module adcsrp_port (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire        i_sclk,
    input  wire        i_cs_n,
    input  wire        i_din,
    output reg         o_dout,
    output wire        o_dout_oe,
    output reg         o_result_ready_n,
    input  wire        i_result_valid,
    input  wire [15:0] i_result_data,
    output wire        o_result_accept,
    output reg  [7:0]  o_setup,
    output reg  [7:0]  o_clock,
    output reg  [7:0]  o_test,
    output reg  [23:0] o_zero_scale,
    output reg  [23:0] o_full_scale,
    output reg  [2:0]  o_comm_ctrl
);

    localparam ST_COMM  = 2'h0;
    localparam ST_WRITE = 2'h1;
    localparam ST_READ  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers, third stage only for edge finding
    reg sclk_s1, sclk_s2, sclk_d;
    reg cs_s1, cs_s2;
    reg din_s1, din_s2;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_d  <= 1'b1;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
        end else begin
            sclk_s1 <= i_sclk;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
            cs_s1   <= i_cs_n;
            cs_s2   <= cs_s1;
            din_s1  <= i_din;
            din_s2  <= din_s1;
        end
    end

    // device samples on rising, shifts on falling edges of the serial clock
    wire sel   = ~cs_s2;
    wire rise  = sel & sclk_s2 & ~sclk_d;
    wire fall  = sel & ~sclk_s2 & sclk_d;

    ////////////////////////////////////////////////////////////////////////////////
    // link state
    reg [1:0]  state;
    reg [4:0]  bit_cnt;
    reg [23:0] shift;
    reg [2:0]  reg_sel;
    reg [5:0]  ones_cnt;
    reg [15:0] data_reg;
    reg        unread;
    reg        upd_pend;

    // transfer length of the selected register
    reg [4:0] sel_len;
    always @* begin
        case (reg_sel)
            `ADCSRP_REG_DATA: sel_len = `ADCSRP_LEN_DATA;
            `ADCSRP_REG_ZERO: sel_len = `ADCSRP_LEN_CAL;
            `ADCSRP_REG_FULL: sel_len = `ADCSRP_LEN_CAL;
            default:          sel_len = `ADCSRP_LEN_BYTE;
        endcase
    end

    // comms byte under assembly, completed by the current input bit
    wire [7:0] comm_byte = {shift[6:0], din_s2};
    wire [2:0] next_sel  = comm_byte[`ADCSRP_COMM_SEL_HI:`ADCSRP_COMM_SEL_LO];
    wire       reading   = (state == ST_READ) && (reg_sel == `ADCSRP_REG_DATA);
    wire       read_done = rise && (state == ST_READ) && (bit_cnt == sel_len - 5'h01);

    // left-aligned image of a register for reading
    reg [23:0] rd_image;
    always @*  begin
        case (next_sel)
            `ADCSRP_REG_COMM:  rd_image = {o_result_ready_n, next_sel, 1'b1,
                                           o_comm_ctrl, 16'h0000};
            `ADCSRP_REG_SETUP: rd_image = {o_setup, 16'h0000};
            `ADCSRP_REG_CLOCK: rd_image = {o_clock, 16'h0000};
            `ADCSRP_REG_DATA:  rd_image = {data_reg, 8'h00};
            `ADCSRP_REG_TEST:  rd_image = {o_test, 16'h0000};
            `ADCSRP_REG_ZERO:  rd_image = o_zero_scale;
            `ADCSRP_REG_FULL:  rd_image = o_full_scale;
            default:           rd_image = 24'h000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial state machine; unknown code 5 is a byte access with no effect
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state        <= ST_COMM;
            bit_cnt      <= 5'h00;
            shift        <= 24'h000000;
            reg_sel      <= `ADCSRP_REG_COMM;
            ones_cnt     <= 6'h00;
            o_dout       <= 1'b0;
            o_setup      <= `ADCSRP_RST_SETUP;
            o_clock      <= `ADCSRP_RST_CLOCK;
            o_test       <= `ADCSRP_RST_TEST;
            o_zero_scale <= `ADCSRP_RST_ZERO;
            o_full_scale <= `ADCSRP_RST_FULL;
            o_comm_ctrl  <= `ADCSRP_RST_CTRL;
        end else if (rise && din_s2 && (ones_cnt == `ADCSRP_ONES_RESET - 6'h01)) begin
            // interface back to idle, register contents untouched
            state    <= ST_COMM;
            bit_cnt  <= 5'h00;
            ones_cnt <= 6'h00;
        end else begin
            // ones counted on any access; a host reading still clocks its line
            if (rise) begin
                ones_cnt <= din_s2 ? ones_cnt + 6'h01 : 6'h00;
            end
            case (state)
                ST_COMM: begin
                    // a leading one is not a command start, so idle ones do nothing
                    if (rise && !(bit_cnt == 5'h00 && din_s2)) begin
                        shift   <= {shift[22:0], din_s2};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `ADCSRP_LEN_BYTE - 5'h01) begin
                            bit_cnt     <= 5'h00;
                            reg_sel     <= next_sel;
                            o_comm_ctrl <= comm_byte[`ADCSRP_COMM_CTRL_HI:0];
                            if (comm_byte[`ADCSRP_COMM_RW]) begin
                                shift <= rd_image;
                                state <= ST_READ;
                            end else if (next_sel != `ADCSRP_REG_COMM) begin
                                state <= ST_WRITE;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    if (rise) begin
                        shift   <= {shift[22:0], din_s2};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == sel_len - 5'h01) begin
                            bit_cnt <= 5'h00;
                            state   <= ST_COMM;
                            case (reg_sel)
                                `ADCSRP_REG_SETUP: o_setup      <= comm_byte;
                                `ADCSRP_REG_CLOCK: o_clock      <= comm_byte;
                                `ADCSRP_REG_TEST:  o_test       <= comm_byte;
                                `ADCSRP_REG_ZERO:  o_zero_scale <= {shift[22:0], din_s2};
                                `ADCSRP_REG_FULL:  o_full_scale <= {shift[22:0], din_s2};
                                default:           o_test       <= o_test;
                            endcase
                        end
                    end
                end
                ST_READ: begin
                    // serial input deliberately not sampled here
                    if (fall) begin
                        o_dout <= shift[23];
                        shift  <= {shift[22:0], 1'b0};
                    end
                    if (rise) begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == sel_len - 5'h01) begin
                            bit_cnt <= 5'h00;
                            state   <= ST_COMM;
                        end
                    end
                end
                default: begin
                    state   <= ST_COMM;
                    bit_cnt <= 5'h00;
                end
            endcase
        end
    end

    // output driven only while selected and reading
    assign o_dout_oe = sel && (state == ST_READ);

    ////////////////////////////////////////////////////////////////////////////////
    // result buffer; the output register refills only once the last result was read,
    // so an unread host makes the buffer fill and push back on the converter
    wire        fifo_valid;
    wire [15:0] fifo_data;
    wire        fifo_pop = upd_pend;

    adcsrp_fifo #(
        .WIDTH (`ADCSRP_DATA_W),
        .DEPTH (`ADCSRP_FIFO_DEPTH),
        .AW    (`ADCSRP_FIFO_AW)
    ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (i_result_valid),
        .i_in_data   (i_result_data),
        .o_in_ready  (o_result_accept),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // output register and ready flag: high for the update cycle, low once loaded
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            data_reg         <= 16'h0000;
            unread           <= 1'b0;
            upd_pend         <= 1'b0;
            o_result_ready_n <= 1'b1;
        end else if (upd_pend) begin
            data_reg         <= fifo_data;
            upd_pend         <= 1'b0;
            unread           <= 1'b1;
            o_result_ready_n <= 1'b0;
        end else if (fifo_valid && !unread && !reading) begin
            upd_pend         <= 1'b1;
            o_result_ready_n <= 1'b1;
        end else if (read_done && (reg_sel == `ADCSRP_REG_DATA)) begin
            unread           <= 1'b0;
            o_result_ready_n <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: tb/adcsrp_port_chk.sv
// checker of the serial register port, bound to the port's top
// assumes the core clock and the synchronous active-low reset of the port
`timescale 1ns/10ps
`default_nettype none
module adcsrp_port_chk (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_sclk,
    input wire logic        i_cs_n,
    input wire logic        o_dout,
    input wire logic        o_dout_oe,
    input wire logic        o_result_ready_n,
    input wire logic        i_result_valid,
    input wire logic        o_result_accept,
    input wire logic [7:0]  o_setup,
    input wire logic [23:0] o_zero_scale
);
    ////////////////////////////////////////////////////////////////
    // cycles since select went high; saturates so long idles stay idle
    logic [3:0] cs_hi;
    always_ff @(posedge i_core_clk) begin
        cs_hi <= (!i_rst_n || !i_cs_n) ? 4'h0 : cs_hi + {3'h0, cs_hi != 4'hF};
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    a_oe_drops: assert property (
        $rose(i_cs_n) |-> ##[1:5] !o_dout_oe) else $error("output enable kept after deselect");
    a_oe_selected: assert property (
        $rose(o_dout_oe) |-> !i_cs_n && !$past(i_cs_n, 3)) else $error("output enabled unselected");
    a_comm_quiet: assert property (
        $fell(i_cs_n) |-> ##3 !o_dout_oe [*8]) else $error("output driven during comms byte");
    a_dout_edge: assert property (
        o_dout_oe && $past(o_dout_oe) && $changed(o_dout) |-> !i_sclk)
        else $error("read bit changed while serial clock high");
    a_ready_rise: assert property (
        i_result_valid && o_result_accept && o_result_ready_n && cs_hi >= 4'h4
        |-> ##[1:3] !o_result_ready_n) else $error("ready pin missed new result");
    a_ready_holds: assert property (
        cs_hi >= 4'h6 && !o_result_ready_n |=> !o_result_ready_n) else $error("ready pin rose idle");
    a_regs_still: assert property (
        cs_hi >= 4'h6 |=> $stable(o_setup) && $stable(o_zero_scale)) else $error("register moved idle");
    a_reset_state: assert property (
        $rose(i_rst_n) |-> o_result_ready_n && o_result_accept && !o_dout_oe && o_setup == 8'h01)
        else $error("wrong state after reset");
endmodule
bind adcsrp_port adcsrp_port_chk chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .o_result_ready_n(o_result_ready_n), .i_result_valid(i_result_valid),
    .o_result_accept(o_result_accept), .o_setup(o_setup), .o_zero_scale(o_zero_scale));
`default_nettype wire

// File: tb/adcsrp_host.sv
// host serial master model: clock idles high, phase one, msb first
// assumes the core clock of the bench; 80 ns serial period
`timescale 1ns/10ps
`default_nettype none
module adcsrp_host (
    input  wire logic i_core_clk,
    input  wire logic i_dout,
    input  wire logic i_dout_oe,
    output var  logic o_sclk,
    output var  logic o_cs_n,
    output var  logic o_din
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end
    // one framed transfer; undriven line reads as inverse of last bit
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        @(posedge i_core_clk) o_cs_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        for (int k = 0; k < n; k++) begin
            o_sclk <= 1'b0;
            o_din  <= tx[n-1-k];
            repeat (5) @(posedge i_core_clk);
            rx = {rx[30:0], i_dout_oe ? i_dout : ~rx[0]};
            o_sclk <= 1'b1;
            repeat (5) @(posedge i_core_clk);
        end
        repeat (6) @(posedge i_core_clk);
        o_cs_n <= 1'b1;
        o_din  <= ~o_din;
        repeat (6) @(posedge i_core_clk);
    endtask
endmodule
`default_nettype wire

// File: tb/adc_serial_register_port_tb.sv
// self-checking bench of the serial register port with a host model
// assumes the port and fifo design files and the constants header
`timescale 1ns/10ps
`default_nettype none
`include "adcsrp_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module adc_serial_register_port_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        vld = 1'b0;
    logic [15:0] dat = 16'h0000;
    logic [31:0] rx;
    int          n_mismatch = 0;
    int          check_count = 0;
    wire         sclk, cs_n, din, dout, oe, rdy_n, acc;
    wire  [7:0]  setup, clkr, test;
    wire  [23:0] zero, full;
    wire  [2:0]  ctrl;
    initial forever #4 clk = ~clk;
    adcsrp_host host_u (.i_core_clk(clk), .i_dout(dout), .i_dout_oe(oe), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_din(din));
    adcsrp_port dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .o_dout(dout), .o_dout_oe(oe), .o_result_ready_n(rdy_n),
        .i_result_valid(vld), .i_result_data(dat), .o_result_accept(acc), .o_setup(setup),
        .o_clock(clkr), .o_test(test), .o_zero_scale(zero), .o_full_scale(full),
        .o_comm_ctrl(ctrl));
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded poll of the ready pin, the way a host would
    task automatic wait_rdy();
        for (int k = 0; k < 400 && rdy_n !== 1'b0; k++) @(posedge clk);
        if (rdy_n !== 1'b0) begin
            n_mismatch++;
            conclude();
        end
    endtask
    // one push, only when the buffer offers room
    task automatic push(input logic [15:0] d, output logic ok);
        @(negedge clk) ok = acc;
        if (ok) begin
            @(posedge clk) vld <= 1'b1;
            dat <= d;
            @(posedge clk) vld <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        `CHK("setup", `ADCSRP_RST_SETUP, setup)
        `CHK("clock", `ADCSRP_RST_CLOCK, clkr)
        `CHK("test", `ADCSRP_RST_TEST, test)
        `CHK("zero", `ADCSRP_RST_ZERO, zero)
        `CHK("full", `ADCSRP_RST_FULL, full)
        `CHK("ready", 1'b1, rdy_n)
    endtask
    // comms and value back to back, then read back with ones on din
    task automatic t_setup();
        host_u.xfer(32'h000010A5, 16, rx);
        `CHK("setup", 8'hA5, setup)
        `CHK("write quiet", 16'hAAAA, rx[15:0])
        // the other byte registers configured the same way after reset
        host_u.xfer(32'h0000205A, 16, rx);
        `CHK("clock", 8'h5A, clkr)
        host_u.xfer(32'h000040C3, 16, rx);
        `CHK("test", 8'hC3, test)
        host_u.xfer(32'h000018FF, 16, rx);
        `CHK("setup read", 8'hA5, rx[7:0])
        `CHK("setup kept", 8'hA5, setup)
    endtask
    task automatic t_cal();
        host_u.xfer(32'h65123456, 32, rx);
        `CHK("zero", 24'h123456, zero)
        `CHK("ctrl", 3'h5, ctrl)
        host_u.xfer(32'h78000000, 32, rx);
        `CHK("full read", `ADCSRP_RST_FULL, rx[23:0])
    endtask
    task automatic t_result();
        logic ok;
        push(16'hBEEF, ok);
        wait_rdy();
        host_u.xfer(32'h00000800, 16, rx);
        `CHK("status", 8'h08, rx[7:0])
        host_u.xfer(32'h00380000, 24, rx);
        `CHK("data", 16'hBEEF, rx[15:0])
        `CHK("ready after read", 1'b1, rdy_n)
        host_u.xfer(32'h00000800, 16, rx);
        `CHK("status idle", 8'h88, rx[7:0])
    endtask
    // fill until refused, then drain in order
    task automatic t_fifo();
        logic ok;
        int   cnt;
        ok = 1'b1;
        cnt = 0;
        while (ok && cnt < 20) begin
            push(16'h1000 + cnt[15:0], ok);
            cnt += int'(ok);
        end
        `CHK("held", `ADCSRP_FIFO_DEPTH + 1, cnt)
        for (int i = 0; i < cnt; i++) begin
            wait_rdy();
            host_u.xfer(32'h00380000, 24, rx);
            `CHK("fifo data", 16'h1000 + i[15:0], rx[15:0])
        end
        `CHK("drained", 1'b1, rdy_n & acc)
    endtask
    task automatic t_ones();
        host_u.xfer(32'h00000001, 3, rx);
        host_u.xfer(32'hFFFFFFFF, 32, rx);
        host_u.xfer(32'h00001033, 16, rx);
        `CHK("setup after ones", 8'h33, setup)
        `CHK("zero kept", 24'h123456, zero)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_vals();
        t_setup();
        t_cal();
        t_result();
        t_fifo();
        t_ones();
        conclude();
    end
endmodule
`default_nettype wire
